/* bench/gtc_src_model.sv */
// far-side model: external count pin, low-power oscillator and gate pin
`timescale 1ns/1ns
`default_nettype none
module gtc_src_model (
  input  wire logic clk_i,
  output logic      ext_clk_o,
  output logic      lp_clk_o,
  output logic      gate_o
);
  logic lvl   = 1'b1;
  logic to_lp = 1'b0;

  // only the selected line carries edges, the other rests low
  assign ext_clk_o = to_lp ? 1'b0 : lvl;
  assign lp_clk_o  = to_lp ? lvl : 1'b0;

  initial gate_o = 1'b0;

  task automatic level(input logic v);
    @(posedge clk_i);
    lvl <= v;
  endtask : level

  task automatic use_lp(input logic v);
    @(posedge clk_i);
    to_lp <= v;
  endtask : use_lp

  task automatic set_gate(input logic v);
    @(posedge clk_i);
    gate_o <= v;
  endtask : set_gate

  // n pairs of level changes, four clocks apart to clear the sync pipe
  task automatic pairs(input int n);
    repeat (2 * n) begin
      @(posedge clk_i);
      lvl <= ~lvl;
      repeat (3) @(posedge clk_i);
    end
  endtask : pairs
endmodule : gtc_src_model
`default_nettype wire

/* bench/gtc_top_tb.sv */
// self-checking bench for the gated 16-bit timer/counter
`timescale 1ns/1ns
`default_nettype none
`include "gtc_consts.svh"
module gtc_top_tb;
  localparam logic [7:0] IC = `GTC_IDX_INT_CONTROL;
  localparam logic [7:0] FL = `GTC_IDX_PERIPH_FLAGS;
  localparam logic [7:0] LO = `GTC_IDX_COUNT_LOW;
  localparam logic [7:0] HI = `GTC_IDX_COUNT_HIGH;
  localparam logic [7:0] CT = `GTC_IDX_COUNTER_CTRL;
  localparam logic [7:0] EN = `GTC_IDX_PERIPH_ENABLES;
  logic        clk_i  = 1'b0;
  logic        rst_i  = 1'b1;
  logic        cyc    = 1'b0;
  logic        stb    = 1'b0;
  logic        we     = 1'b0;
  logic [11:0] adr    = 12'h000;
  logic [31:0] wdat   = 32'h00000000;
  logic [3:0]  sel    = 4'h0;
  logic [3:0]  bsel   = 4'hF;
  logic        internal_oscillator = 1'b0;
  logic        slp    = 1'b0;
  logic [31:0] rdat;
  logic        ack, lp_en, irq, wake, wake_isr;
  logic        ext_clk, lp_clk, gate;
  logic [7:0]  r;
  logic [7:0]  regs [7] = '{IC, FL, LO, HI, CT, EN, 8'hFF};
  logic [7:0]  gctl [4] = '{8'h41, 8'h41, 8'h01, 8'h40};
  int          err_count    = 0;
  int          total_checks = 0;

  always #50 clk_i = ~clk_i;

  gtc_top uut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .external_count_clock_i(ext_clk),
    .lp_osc_clk_i(lp_clk), .gate_input_pin_i(gate),
    .internal_oscillator_noclkout_i(internal_oscillator), .sleep_i(slp), .lp_osc_en_o(lp_en),
    .irq_o(irq), .wake_o(wake), .wake_isr_o(wake_isr)
  );

  gtc_src_model src (
    .clk_i(clk_i), .ext_clk_o(ext_clk), .lp_clk_o(lp_clk), .gate_o(gate)
  );

  task automatic test_done;
    if (err_count == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : test_done

  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s exp %0h got %0h", nm, e, g);
    end
  endtask : chk

  task automatic chk_rng(input string nm, input int lo, input int hi,
                         input logic [7:0] g);
    total_checks++;
    if ($isunknown(g) || g < lo || g > hi) begin
      err_count++;
      $display("BAD %s exp %0d..%0d got %0h", nm, lo, hi, g);
    end
  endtask : chk_rng

  // classic single cycle; the wait on ack is bounded
  task automatic bus(input logic w, input logic [7:0] idx,
                     input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    sel  <= bsel;
    adr  <= {2'h0, idx, 2'h0};
    wdat <= {24'h000000, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 16);
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1) begin
      err_count++;
      test_done();
    end
  endtask : bus

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d, r);
  endtask : wr

  task automatic rc(input logic [7:0] idx, input logic [7:0] e,
                    input string nm);
    bus(1'b0, idx, 8'h00, r);
    chk(nm, e, r);
  endtask : rc

  task automatic setcnt(input logic [15:0] v);
    wr(LO, v[7:0]);
    wr(HI, v[15:8]);
  endtask : setcnt

  // counter is stopped again before anything is read or rewritten
  task automatic run(input logic [7:0] c, input int n);
    wr(CT, c);
    repeat (n) @(posedge clk_i);
    wr(CT, 8'h00);
  endtask : run

  // pin level is settled before enabling, so no stray edge is seen
  task automatic ext_run(input logic [7:0] c, input logic st,
                         input int n, input logic [7:0] e);
    src.level(st);
    setcnt(16'h0000);
    wr(CT, c);
    src.pairs(n);
    repeat (6) @(posedge clk_i);
    wr(CT, 8'h00);
    rc(LO, e, "ext count");
  endtask : ext_run

  // hang guard
  initial begin
    repeat (100000) @(posedge clk_i);
    err_count++;
    test_done();
  end

  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (regs[i]) rc(regs[i], 8'h00, "reset value");
    wr(CT, 8'hFE);
    rc(CT, 8'h7E, "control");
    wr(CT, 8'h00);
    wr(8'hFF, 8'hFF);
    rc(8'hFF, 8'h00, "unmapped");
    // a write without byte lane zero must leave the register alone
    bsel = 4'hE;
    wr(CT, 8'h01);
    bsel = 4'hF;
    rc(CT, 8'h00, "lane off");
    setcnt(16'h5AA5);
    rc(LO, 8'hA5, "load low");
    rc(HI, 8'h5A, "load high");
    for (int p = 0; p < 4; p++) begin
      setcnt(16'h0000);
      run({2'h0, p[1:0], 4'h1}, 80 << p);
      bus(1'b0, LO, 8'h00, r);
      chk_rng("prescaled", 19, 21, r);
    end
    setcnt(16'hFFFE);
    run(8'h01, 20);
    rc(HI, 8'h00, "wrap high");
    rc(FL, 8'h01, "ovf flag");
    for (int i = 0; i < 8; i++) begin
      wr(EN, {7'h00, i[0]});
      wr(IC, {i[2], i[1], 6'h00});
      @(posedge clk_i);
      chk("irq", {7'h00, i == 7}, {7'h00, irq});
    end
    rc(FL, 8'h01, "flag held");
    wr(FL, 8'h00);
    rc(FL, 8'h00, "flag clear");
    chk("irq off", 8'h00, {7'h00, irq});
    wr(IC, 8'h00);
    for (int g = 0; g < 4; g++) begin
      src.set_gate(g[0] == 0);
      setcnt(16'h0000);
      run(gctl[g], 40);
      bus(1'b0, LO, 8'h00, r);
      chk("gated", {7'h00, g == 1 || g == 2}, {7'h00, r != 8'h00});
    end
    src.set_gate(1'b0);
    for (int s = 0; s < 2; s++) begin
      ext_run({5'h00, s[0], 2'h3}, 1'b1, 5, 8'h05);
      ext_run({5'h00, s[0], 2'h3}, 1'b0, 5, 8'h04);
    end
    wr(CT, 8'h08);
    @(posedge clk_i);
    chk("lp enable", 8'h00, {7'h00, lp_en});
    internal_oscillator <= 1'b1;
    @(posedge clk_i);
    @(posedge clk_i);
    chk("lp enable", 8'h01, {7'h00, lp_en});
    src.use_lp(1'b1);
    ext_run(8'h0B, 1'b1, 3, 8'h03);
    slp <= 1'b1;
    ext_run(8'h0F, 1'b1, 3, 8'h03);
    src.use_lp(1'b0);
    ext_run(8'h03, 1'b1, 3, 8'h00);
    wr(FL, 8'h00);
    setcnt(16'h0000);
    wr(EN, 8'h01);
    setcnt(16'hFFFF);
    wr(IC, 8'h40);
    wr(CT, 8'h07);
    src.pairs(2);
    repeat (6) @(posedge clk_i);
    chk("wake", 8'h01, {7'h00, wake});
    chk("wake isr", 8'h00, {7'h00, wake_isr});
    rc(LO, 8'h01, "async read");
    wr(IC, 8'hC0);
    @(posedge clk_i);
    chk("wake isr", 8'h01, {7'h00, wake_isr});
    wr(CT, 8'h00);
    @(posedge clk_i);
    chk("wake off", 8'h00, {7'h00, wake});
    // second reset in mid-run: every register must return to zero
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (regs[i]) rc(regs[i], 8'h00, "rerun reset");
    test_done();
  end
endmodule : gtc_top_tb
`default_nettype wire

/* inc/gtc_consts.svh */
// register offsets, field positions, reset values and timing counts
`ifndef GTC_CONSTS_SVH
`define GTC_CONSTS_SVH
// register indices; byte address is four times the index
`define GTC_IDX_INT_CONTROL    8'h0B
`define GTC_IDX_PERIPH_FLAGS   8'h0C
`define GTC_IDX_COUNT_LOW      8'h0E
`define GTC_IDX_COUNT_HIGH     8'h0F
`define GTC_IDX_COUNTER_CTRL   8'h10
`define GTC_IDX_PERIPH_ENABLES 8'h8C
// interrupt_control fields
`define GTC_BIT_GIE            7
`define GTC_BIT_PERIPHERAL_INTERRUPT_ENABLE           6
// peripheral flag / enable fields
`define GTC_BIT_OVF            0
// counter_control fields
`define GTC_BIT_GATE_EN        6
`define GTC_BIT_PRESC_HI       5
`define GTC_BIT_PRESC_LO       4
`define GTC_BIT_LP_OSC_EN      3
`define GTC_BIT_SYNC_CTRL      2
`define GTC_BIT_CLK_SRC        1
`define GTC_BIT_ON             0
// reset values
`define GTC_RST_INT_CONTROL    8'h00
`define GTC_RST_PERIPH_FLAGS   8'h00
`define GTC_RST_PERIPH_ENABLES 8'h00
`define GTC_RST_COUNTER_CTRL   8'h00
`define GTC_RST_COUNT          16'h0000
`define GTC_COUNT_MAX          16'hFFFF
// instruction cycle is the oscillator divided by four
`define GTC_INSTR_DIV          4
`endif

/* inc/gtc_pkg.sv */
// types shared by the gated timer/counter
package gtc_pkg;
  typedef enum logic [1:0] {
    GTC_PRESC_DIV1 = 2'h0,
    GTC_PRESC_DIV2 = 2'h1,
    GTC_PRESC_DIV4 = 2'h2,
    GTC_PRESC_DIV8 = 2'h3
  } gtc_presc_t;
endpackage : gtc_pkg

/* inc/gtc_pre_if.sv */
// link between the counter core and its prescaler
`timescale 1ns/1ns
`default_nettype none
interface gtc_pre_if;
  logic              tick;
  logic              clr;
  gtc_pkg::gtc_presc_t sel;
  logic              pulse;
  modport core   (output tick, output clr, output sel, input pulse);
  modport scaler (input tick, input clr, input sel, output pulse);
endinterface : gtc_pre_if
`default_nettype wire

/* rtl/gtc_prescaler.sv */
// 1/2/4/8 prescaler for the count source
`timescale 1ns/1ns
`default_nettype none
module gtc_prescaler (
  input  wire logic  clk_i,
  input  wire logic  rst_i,
  gtc_pre_if.scaler  pre
);
  logic [2:0] cnt_ff;
  logic [2:0] mask;

  // low bits that must all be set before a pulse passes
  always_comb begin
    unique case (pre.sel)
      gtc_pkg::GTC_PRESC_DIV1: mask = 3'h0;
      gtc_pkg::GTC_PRESC_DIV2: mask = 3'h1;
      gtc_pkg::GTC_PRESC_DIV4: mask = 3'h3;
      gtc_pkg::GTC_PRESC_DIV8: mask = 3'h7;
    endcase
  end

  // pulse is combinational so gating acts in the same cycle
  assign pre.pulse = pre.tick && ((cnt_ff & mask) == mask); // R10

  // clear on any count byte write; not visible to software
  always_ff @(posedge clk_i) begin
    if (rst_i || pre.clr) begin
      cnt_ff <= 3'h0; // R11
    end else if (pre.tick) begin
      cnt_ff <= cnt_ff + 3'h1;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_presc_clear: assert property (pre.clr |=> cnt_ff == 3'h0) // R11
    else $error("prescale counter not cleared by count write");
  a_presc_div8: assert property ( // R10
    pre.sel == gtc_pkg::GTC_PRESC_DIV8 && pre.pulse
    |-> ##1 (!pre.pulse)[*3])
    else $error("divide by eight passed pulses too close");
endmodule : gtc_prescaler
`default_nettype wire

/* rtl/gtc_top.sv */
// gated 16-bit timer/counter with a classic wishbone register slave
//
// Functional notes
// R1: sixteen-bit count in two bytes wraps from all ones to zero.
// R2: every wrap to zero sets the overflow flag.
// R3: interrupt forwarded only with overflow, peripheral and global enables set.
// R4: overflow flag stays set until software clears it.
// R5: internal source counts once per instruction cycle, oscillator over four.
// R6: external source counts rising pin edges, synchronised or not.
// R7: in counter mode a falling edge must precede the first counted rise.
// R8: with gate enable set, counting only while gate pin is low.
// R9: on bit clear stops counting and makes gate enable irrelevant.
// R10: prescale field divides source by one, two, four or eight.
// R11: prescaler hidden from software, cleared by any count byte write.
// R12: clock source bit picks external pin edges or instruction clock.
// R13: sync bit chooses unsynchronised external path; ignored for internal.
// R14: asynchronous counter keeps counting in sleep and can wake.
// R15: count bytes always read as clean values.
// R16: software stops counter before writing and handles wraps between reads.
// R17: low-power oscillator enable acts only with internal osc, no clkout.
// R18: low-power oscillator keeps running during sleep.
// R19: only asynchronous mode counts in sleep; wake needs on and enables.
// R20: wake branches to service only when global enable is set.
// R21: software clears count and flag before enabling the interrupt.
// R22: a count byte write loads that byte; counting resumes from it.
`timescale 1ns/1ns
`default_nettype none
`include "gtc_consts.svh"
module gtc_top #(
  parameter int ADDR_W = 12
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [ADDR_W-1:0] wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  input  wire logic              external_count_clock_i,
  input  wire logic              lp_osc_clk_i,
  input  wire logic              gate_input_pin_i,
  input  wire logic              internal_oscillator_noclkout_i,
  input  wire logic              sleep_i,
  output logic                   lp_osc_en_o,
  output logic                   irq_o,
  output logic                   wake_o,
  output logic                   wake_isr_o
);
  // software visible state
  logic [15:0] count_ff;
  logic [7:0]  counter_control_ff;
  logic        gie_ff;
  logic        peripheral_interrupt_enable_ff;
  logic        ovf_flag_ff;
  logic        ovf_ie_ff;
  // bus slave state
  logic        ack_ff;
  logic [31:0] rdata_ff;
  // count source state
  logic [1:0]  instr_div_ff;
  logic        pin_raw_ff;
  logic        pin_meta_ff;
  logic        pin_sync_ff;
  logic        lvl_prev_ff;
  logic        armed_ff;

  // decoded control fields
  logic        counter_on;
  logic        gate_enable;
  logic        low_power_osc_enable;
  logic        sync_control;
  logic        clock_source_select;
  // bus decode
  logic        bus_req;
  logic        wr_commit;
  logic [7:0]  reg_idx;
  logic [7:0]  wbyte;
  logic        wr_ctrl;
  logic        wr_low;
  logic        wr_high;
  logic        wr_flags;
  logic        wr_intctl;
  logic        wr_enables;
  // counting
  logic        instr_tick;
  logic        ext_lvl;
  logic        ext_rise;
  logic        ext_fall;
  logic        src_tick;
  logic        gate_open;
  logic        sleep_ok;
  logic        inc;
  logic        wrap;
  logic        pin_sel;

  gtc_pre_if pre_if ();

  assign counter_on           = counter_control_ff[`GTC_BIT_ON];
  assign gate_enable          = counter_control_ff[`GTC_BIT_GATE_EN];
  assign low_power_osc_enable = counter_control_ff[`GTC_BIT_LP_OSC_EN];
  assign sync_control         = counter_control_ff[`GTC_BIT_SYNC_CTRL];
  assign clock_source_select  = counter_control_ff[`GTC_BIT_CLK_SRC];

  // ---- wishbone slave ----
  // the register index is the word address; bits above it are ignored
  assign bus_req   = wb_cyc_i && wb_stb_i;
  assign reg_idx   = wb_adr_i[9:2];
  // a write lands at the edge where the master sees ack
  assign wr_commit = bus_req && ack_ff && wb_we_i && wb_sel_i[0];
  assign wbyte     = wb_dat_i[7:0];
  assign wr_ctrl    = wr_commit && reg_idx == `GTC_IDX_COUNTER_CTRL;
  assign wr_low     = wr_commit && reg_idx == `GTC_IDX_COUNT_LOW;
  assign wr_high    = wr_commit && reg_idx == `GTC_IDX_COUNT_HIGH;
  assign wr_flags   = wr_commit && reg_idx == `GTC_IDX_PERIPH_FLAGS;
  assign wr_intctl  = wr_commit && reg_idx == `GTC_IDX_INT_CONTROL;
  assign wr_enables = wr_commit && reg_idx == `GTC_IDX_PERIPH_ENABLES;

  // ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= bus_req && !ack_ff;
    end
  end

  // read data sampled when ack rises; count is a plain flop so any
  // byte read is a settled value, never a half-updated one
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_ff <= 32'h00000000;
    end else if (bus_req && !ack_ff) begin
      rdata_ff <= 32'h00000000;
      unique case (reg_idx)
        `GTC_IDX_INT_CONTROL: begin
          rdata_ff[`GTC_BIT_GIE]  <= gie_ff;
          rdata_ff[`GTC_BIT_PERIPHERAL_INTERRUPT_ENABLE] <= peripheral_interrupt_enable_ff;
        end
        `GTC_IDX_PERIPH_FLAGS:   rdata_ff[`GTC_BIT_OVF] <= ovf_flag_ff;
        `GTC_IDX_COUNT_LOW:      rdata_ff[7:0] <= count_ff[7:0]; // R15
        `GTC_IDX_COUNT_HIGH:     rdata_ff[7:0] <= count_ff[15:8]; // R15
        `GTC_IDX_COUNTER_CTRL:   rdata_ff[7:0] <= counter_control_ff;
        `GTC_IDX_PERIPH_ENABLES: rdata_ff[`GTC_BIT_OVF] <= ovf_ie_ff;
        default:                 rdata_ff <= 32'h00000000;
      endcase
    end
  end

  assign wb_dat_o = rdata_ff;
  assign wb_ack_o = ack_ff;

  // counter control; bit 7 is unimplemented and reads zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      counter_control_ff <= `GTC_RST_COUNTER_CTRL;
    end else if (wr_ctrl) begin
      counter_control_ff <= {1'b0, wbyte[6:0]};
    end
  end

  // global and peripheral enables; other bits belong to other blocks
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gie_ff  <= 1'(`GTC_RST_INT_CONTROL >> `GTC_BIT_GIE);
      peripheral_interrupt_enable_ff <= 1'(`GTC_RST_INT_CONTROL >> `GTC_BIT_PERIPHERAL_INTERRUPT_ENABLE);
    end else if (wr_intctl) begin
      gie_ff  <= wbyte[`GTC_BIT_GIE];
      peripheral_interrupt_enable_ff <= wbyte[`GTC_BIT_PERIPHERAL_INTERRUPT_ENABLE];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ovf_ie_ff <= 1'(`GTC_RST_PERIPH_ENABLES >> `GTC_BIT_OVF);
    end else if (wr_enables) begin
      ovf_ie_ff <= wbyte[`GTC_BIT_OVF];
    end
  end

  // ---- count sources ----
  // instruction clock: one tick every fourth oscillator cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      instr_div_ff <= 2'h0;
    end else begin
      instr_div_ff <= instr_div_ff + 2'h1;
    end
  end
  assign instr_tick = instr_div_ff == 2'(`GTC_INSTR_DIV - 1); // R5

  // low-power oscillator replaces the pin only on internal osc, no clkout
  assign lp_osc_en_o = low_power_osc_enable && internal_oscillator_noclkout_i; // R17
  // enable ignores sleep so the oscillator keeps running there
  assign pin_sel = lp_osc_en_o ? lp_osc_clk_i
                               : external_count_clock_i; // R18

  // input register, then a two-stage synchroniser for sync mode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_raw_ff  <= 1'b0;
      pin_meta_ff <= 1'b0;
      pin_sync_ff <= 1'b0;
    end else begin
      pin_raw_ff  <= pin_sel;
      pin_meta_ff <= pin_raw_ff;
      pin_sync_ff <= pin_meta_ff;
    end
  end

  // unsynchronised path skips the two extra stages: lower latency,
  // but edges are not aligned to the instruction phase
  assign ext_lvl = sync_control ? pin_raw_ff : pin_sync_ff; // R13

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lvl_prev_ff <= 1'b0;
    end else begin
      lvl_prev_ff <= ext_lvl;
    end
  end
  assign ext_rise = ext_lvl && !lvl_prev_ff; // R6
  assign ext_fall = !ext_lvl && lvl_prev_ff;

  // a pin low at enable must not count its first rise; a falling edge must come first
  always_ff @(posedge clk_i) begin
    if (rst_i || !counter_on) begin
      armed_ff <= 1'b0; // R7
    end else if (ext_fall) begin
      armed_ff <= 1'b1; // R7
    end
  end

  // source select: pin edges once armed, else instruction clock
  assign src_tick = clock_source_select ? (ext_rise && armed_ff) // R12
                                        : instr_tick; // R5
  // gate pin low-active, only looked at while the counter is on
  assign gate_open = counter_on && (!gate_enable || !gate_input_pin_i); // R8 R9
  // in sleep only the asynchronous external counter runs
  assign sleep_ok = !sleep_i ||
                    (clock_source_select && sync_control); // R14 R19

  assign pre_if.tick = src_tick && gate_open && sleep_ok;
  assign pre_if.clr  = wr_low || wr_high; // R11
  assign pre_if.sel  = gtc_pkg::gtc_presc_t'(counter_control_ff[
                         `GTC_BIT_PRESC_HI:`GTC_BIT_PRESC_LO]); // R10

  gtc_prescaler u_presc (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .pre   (pre_if.scaler)
  );

  assign inc  = pre_if.pulse;
  assign wrap = inc && count_ff == `GTC_COUNT_MAX;

  // ---- counter ----
  // a write wins over a coinciding increment; software avoids the race
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_ff <= `GTC_RST_COUNT;
    end else if (wr_low) begin
      count_ff[7:0] <= wbyte; // R22
    end else if (wr_high) begin
      count_ff[15:8] <= wbyte; // R22
    end else if (inc) begin
      count_ff <= count_ff + 16'h0001; // R1
    end
  end

  // overflow flag: a wrap in the clearing cycle still sets it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ovf_flag_ff <= 1'(`GTC_RST_PERIPH_FLAGS >> `GTC_BIT_OVF);
    end else if (wrap) begin
      ovf_flag_ff <= 1'b1; // R2
    end else if (wr_flags) begin
      ovf_flag_ff <= wbyte[`GTC_BIT_OVF]; // R4
    end
  end

  // ---- interrupt and wake ----
  assign irq_o = ovf_flag_ff && ovf_ie_ff && peripheral_interrupt_enable_ff && gie_ff; // R3
  // wake needs on, overflow enable and peripheral enable
  assign wake_o = sleep_i && ovf_flag_ff && counter_on &&
                  ovf_ie_ff && peripheral_interrupt_enable_ff; // R19
  // with global enable the wake also enters the service routine
  assign wake_isr_o = wake_o && gie_ff; // R20

  // ---- checks ----
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_wrap;
    inc && !wr_low && !wr_high && count_ff == `GTC_COUNT_MAX;
  endsequence

  sequence s_zero_flagged;
    count_ff == 16'h0000 && ovf_flag_ff;
  endsequence

  a_wrap_to_zero: assert property (s_wrap |=> count_ff == 16'h0000) // R1
    else $error("count did not wrap to zero");
  a_flag_on_wrap: assert property (s_wrap |=> s_zero_flagged) // R2
    else $error("overflow flag not set on wrap");
  a_irq_gating: assert property ( // R3
    irq_o |-> gie_ff && peripheral_interrupt_enable_ff && ovf_ie_ff && ovf_flag_ff)
    else $error("interrupt forwarded without all enables");
  a_flag_sticky: assert property ( // R4
    ovf_flag_ff && !wr_flags |=> ovf_flag_ff)
    else $error("overflow flag dropped without software clear");
  a_instr_spacing: assert property ( // R5
    !clock_source_select && inc && pre_if.sel == gtc_pkg::GTC_PRESC_DIV1
    |=> (!inc)[*3])
    else $error("internal count faster than instruction clock");
  a_unarmed_hold: assert property ( // R7
    clock_source_select && !armed_ff && !wr_low && !wr_high
    |=> $stable(count_ff))
    else $error("rise counted before a falling edge");
  a_gate_holds: assert property ( // R8
    counter_on && gate_enable && gate_input_pin_i && !wr_low && !wr_high
    |=> $stable(count_ff))
    else $error("counted while gate pin high");
  a_off_holds: assert property ( // R9
    !counter_on && !wr_low && !wr_high |=> $stable(count_ff))
    else $error("counted while switched off");
  a_sleep_sync: assert property ( // R19
    sleep_i && !(clock_source_select && sync_control) &&
    !wr_low && !wr_high |=> $stable(count_ff))
    else $error("synchronous mode counted in sleep");
  a_byte_load: assert property ( // R22
    wr_low |=> count_ff[7:0] == $past(wbyte))
    else $error("low byte write not loaded");
  a_ack_one: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
endmodule : gtc_top
`default_nettype wire
